// >>> rtl/mac_tx_pkg.sv
package mac_tx_pkg;

    // System clock rate in hertz
    localparam int unsigned SYS_CLK_HZ = 10_000_000;

    // Reference clock rates in hertz
    localparam int unsigned CLK_GIG_HZ = 125_000_000;
    localparam int unsigned CLK_FAST_HZ = 25_000_000;
    localparam int unsigned CLK_SLOW_HZ = 2_500_000;

    // Width of the clock divider counters
    localparam int unsigned DIV_W = 8;

    // Half period in system cycles, rounded down, never below one cycle
    function automatic logic [DIV_W-1:0] half_count(input int unsigned freq_hz);
        int unsigned cnt;
        cnt = SYS_CLK_HZ / (2 * freq_hz);
        if (cnt < 1) begin
            cnt = 1;
        end
        return cnt[DIV_W-1:0];
    endfunction

    localparam logic [DIV_W-1:0] HALF_GIG = half_count(CLK_GIG_HZ);
    localparam logic [DIV_W-1:0] HALF_FAST = half_count(CLK_FAST_HZ);
    localparam logic [DIV_W-1:0] HALF_SLOW = half_count(CLK_SLOW_HZ);

    // Transmit data path geometry
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned FIFO_DEPTH = 16;

    // Link speed codes
    typedef enum logic [1:0] {
        SPEED_10 = 2'h0,
        SPEED_100 = 2'h1,
        SPEED_1000 = 2'h2
    } link_speed_t;

    // Transmit clock pin role, one-hot
    typedef enum logic [1:0] {
        ROLE_CLK_IN = 2'h1,
        ROLE_CLK_OUT = 2'h2
    } tx_clk_role_t;

    // One received transmit word
    typedef struct packed {
        logic wide;
        logic tx_err;
        logic [NIBBLE_W-1:0] nib_hi;
        logic [NIBBLE_W-1:0] nib_lo;
    } tx_word_t;

    localparam int unsigned TX_WORD_W = $bits(tx_word_t);

    // Pin role selection and general-purpose drive values
    typedef struct packed {
        logic col_gpio;
        logic crs_gpio;
        logic col_gpio_out;
        logic col_gpio_oe;
        logic crs_gpio_out;
        logic crs_gpio_oe;
    } pin_role_sel_t;

    localparam logic RESET_LOW = 1'b0;

endpackage

// >>> rtl/async_fifo.sv
`timescale 1ns/10ps
module async_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic wr_ce,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst,
    input wire logic rd_ce,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // Storage, written on the link side only
    logic [WIDTH-1:0] mem [DEPTH];

    // Binary and gray pointers, one extra bit for full detection
    logic [AW:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
    logic [AW:0] rgray_meta_ff, rgray_sync_ff, wgray_meta_ff, wgray_sync_ff;
    logic [AW:0] nxt_wbin, nxt_rbin;
    wire wr_fire = wr_ce && wr_valid && wr_ready;
    wire rd_fire = rd_ce && rd_valid && rd_ready;

    assign nxt_wbin = wbin_ff + (AW+1)'(wr_fire);
    assign nxt_rbin = rbin_ff + (AW+1)'(rd_fire);

    // Full when the gray pointers differ only in the two top bits
    assign wr_ready = (wgray_ff != {~rgray_sync_ff[AW:AW-1], rgray_sync_ff[AW-2:0]});
    assign rd_valid = (rgray_ff != wgray_sync_ff);
    assign rd_data = mem[rbin_ff[AW-1:0]];

    // Write side pointer and storage
    always_ff @(posedge wr_clk) begin
        if (wr_fire) begin
            mem[wbin_ff[AW-1:0]] <= wr_data;
        end
        if (wr_rst) begin
            wbin_ff <= '0;
            wgray_ff <= '0;
        end else begin
            wbin_ff <= nxt_wbin;
            wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
        end
    end

    // Read pointer brought over in gray code, two stages
    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            rgray_meta_ff <= '0;
            rgray_sync_ff <= '0;
        end else begin
            rgray_meta_ff <= rgray_ff;
            rgray_sync_ff <= rgray_meta_ff;
        end
    end

    // Read side pointer
    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rbin_ff <= '0;
            rgray_ff <= '0;
        end else begin
            rbin_ff <= nxt_rbin;
            rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
        end
    end

    // Write pointer brought over in gray code, two stages
    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            wgray_meta_ff <= '0;
            wgray_sync_ff <= '0;
        end else begin
            wgray_meta_ff <= wgray_ff;
            wgray_sync_ff <= wgray_meta_ff;
        end
    end
endmodule // async_fifo

// >>> rtl/mac_tx_if.sv
`timescale 1ns/10ps
// Function
// (RULE_01) Half duplex: collision high on simultaneous activity
// (RULE_02) Collision is asynchronous; MAC must synchronise it
// (RULE_03) Half duplex: carrier sense on receive or transmit
// (RULE_04) Collision, carrier pins default; GPIO via role select
// (RULE_05) Four transmit data bits sampled on transmit clock
// (RULE_06) RGMII: MAC drives continuous transmit clock input
// (RULE_07) MII: device drives 25 or 2.5 MHz clock; at 100 Mb/s the divider gives 5 MHz from the 10 MHz system clock
// (RULE_08) Transmit clock pin defaults to input after reset
// (RULE_09) Selecting MII switches clock pin to output automatically
// (RULE_10) Transmit control: enable/error DDR, MII plain enable
// (RULE_11) Receive clock rate follows speed, slow without link; the divider gives 5 MHz at both 100 and 1000 Mb/s
// (RULE_12) Collision held low in full duplex
module mac_tx_if
    import mac_tx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic [mac_tx_pkg::NIBBLE_W-1:0] tx_data_pin,
    input wire logic tx_ctl_pin,
    output logic tx_clk_out,
    output logic tx_clk_oe,
    output logic rx_clk_out,
    input wire logic mii_select,
    input wire logic tx_clk_out_cfg,
    input wire mac_tx_pkg::link_speed_t speed,
    input wire logic link_up,
    input wire logic half_duplex,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire mac_tx_pkg::pin_role_sel_t pin_role_select_register,
    input wire logic col_in,
    output logic col_out,
    output logic col_oe,
    input wire logic crs_in,
    output logic crs_out,
    output logic crs_oe,
    output logic col_gpio_in,
    output logic crs_gpio_in,
    output logic tx_word_valid,
    input wire logic tx_word_ready,
    output mac_tx_pkg::tx_word_t tx_word,
    output logic tx_overrun
);
    import mac_tx_pkg::*;

    // Link side: reset, clock enable and mode brought onto the link clock
    logic rst_link_meta_ff, rst_link_ff;
    logic ce_link_meta_ff, ce_link_ff;
    logic mii_link_meta_ff, mii_link_ff;

    // Link side capture of the pins on both edges
    logic [NIBBLE_W-1:0] rise_nib_ff, fall_nib_ff;
    logic rise_ctl_ff, fall_ctl_ff;
    logic rise_seen_ff;
    logic overrun_link_ff;

    // Word offered to the FIFO from the link side
    tx_word_t link_word;
    logic link_push;
    logic fifo_wr_ready;

    // System side view of the FIFO
    logic fifo_rd_valid;
    tx_word_t fifo_rd_data;
    logic fifo_pop;

    // System side output flops
    logic tx_word_valid_ff;
    tx_word_t tx_word_ff;
    logic overrun_meta_ff, tx_overrun_ff;
    logic col_out_ff, col_oe_ff, crs_out_ff, crs_oe_ff;
    logic col_meta_ff, col_gpio_in_ff, crs_meta_ff, crs_gpio_in_ff;

    // Transmit clock role machine
    tx_clk_role_t role_ff, nxt_role;

    // Clock dividers for the driven clocks
    logic [DIV_W-1:0] tx_div_ff, rx_div_ff, tx_half, rx_half;
    logic tx_clk_out_ff, tx_clk_oe_ff, rx_clk_out_ff;

    // Activity decode shared by both indication pins
    wire collision_now = half_duplex && rx_active && tx_active; // see (RULE_01) see (RULE_12)
    wire carrier_now = half_duplex && (rx_active || tx_active); // see (RULE_03)
    wire want_clk_out = mii_select || tx_clk_out_cfg; // see (RULE_09)

    // Divider half periods chosen from the speed
    assign tx_half = (speed == SPEED_10) ? HALF_SLOW : HALF_FAST; // see (RULE_07)
    assign rx_half = !link_up ? HALF_SLOW :
                     (speed == SPEED_1000) ? HALF_GIG :
                     (speed == SPEED_100) ? HALF_FAST : HALF_SLOW; // see (RULE_11)

    // Link side synchronisers; only the second stage is read
    always_ff @(posedge link_clk) begin
        rst_link_meta_ff <= reset;
        rst_link_ff <= rst_link_meta_ff;
        ce_link_meta_ff <= ce;
        ce_link_ff <= ce_link_meta_ff;
        mii_link_meta_ff <= mii_select;
        mii_link_ff <= mii_link_meta_ff;
    end

    // Rising edge capture of data and control
    always_ff @(posedge link_clk) begin
        if (ce_link_ff) begin
            rise_nib_ff <= tx_data_pin; // see (RULE_05)
            rise_ctl_ff <= tx_ctl_pin; // see (RULE_10)
        end
    end

    // Falling edge capture, used only for the double-rate link
    always_ff @(negedge link_clk) begin
        if (ce_link_ff) begin
            fall_nib_ff <= tx_data_pin; // see (RULE_05)
            fall_ctl_ff <= tx_ctl_pin; // see (RULE_10)
        end
    end

    // Word assembly: RGMII carries error as enable xor falling control
    always_comb begin
        link_word = '0;
        if (mii_link_ff) begin
            link_word.nib_lo = rise_nib_ff;
        end else begin
            link_word.wide = 1'b1;
            link_word.nib_lo = rise_nib_ff;
            link_word.nib_hi = fall_nib_ff;
            link_word.tx_err = rise_ctl_ff ^ fall_ctl_ff; // see (RULE_10)
        end
    end

    // A word is pushed one rising edge after its enable was sampled
    assign link_push = rise_seen_ff && rise_ctl_ff;

    // Guard so the first edges after reset push nothing stale
    always_ff @(posedge link_clk) begin
        if (rst_link_ff) begin
            rise_seen_ff <= 1'b0;
        end else if (ce_link_ff) begin
            rise_seen_ff <= 1'b1;
        end
    end

    // Sticky overrun; the MAC cannot be stalled, so a full FIFO drops words
    always_ff @(posedge link_clk) begin
        if (rst_link_ff) begin
            overrun_link_ff <= 1'b0;
        end else if (ce_link_ff && link_push && !fifo_wr_ready) begin
            overrun_link_ff <= 1'b1;
        end
    end

    // Crossing from link clock to system clock
    async_fifo #(
        .WIDTH(TX_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .wr_clk(link_clk),
        .wr_rst(rst_link_ff),
        .wr_ce(ce_link_ff),
        .wr_valid(link_push),
        .wr_ready(fifo_wr_ready),
        .wr_data(link_word),
        .rd_clk(clk_sys),
        .rd_rst(reset),
        .rd_ce(ce),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_rd_data)
    );

    // Pop when the output stage is empty or being drained
    assign fifo_pop = !tx_word_valid_ff || tx_word_ready;

    // Output stage toward the transmit core
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_word_valid_ff <= 1'b0;
            tx_word_ff <= '0;
        end else if (ce && fifo_pop) begin
            tx_word_valid_ff <= fifo_rd_valid;
            if (fifo_rd_valid) begin
                tx_word_ff <= fifo_rd_data;
            end
        end
    end

    // Overrun flag brought into the system domain as a level
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overrun_meta_ff <= 1'b0;
            tx_overrun_ff <= 1'b0;
        end else if (ce) begin
            overrun_meta_ff <= overrun_link_ff;
            tx_overrun_ff <= overrun_meta_ff;
        end
    end

    // Collision and carrier pins: function by default, GPIO on request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            col_out_ff <= 1'b0;
            col_oe_ff <= 1'b1;
            crs_out_ff <= 1'b0;
            crs_oe_ff <= 1'b1;
        end else if (ce) begin
            // Collision pin
            if (pin_role_select_register.col_gpio) begin
                col_out_ff <= pin_role_select_register.col_gpio_out; // see (RULE_04)
                col_oe_ff <= pin_role_select_register.col_gpio_oe;
            end else begin
                col_out_ff <= collision_now; // see (RULE_01) see (RULE_12)
                col_oe_ff <= 1'b1;
            end
            // Carrier sense pin
            if (pin_role_select_register.crs_gpio) begin
                crs_out_ff <= pin_role_select_register.crs_gpio_out; // see (RULE_04)
                crs_oe_ff <= pin_role_select_register.crs_gpio_oe;
            end else begin
                crs_out_ff <= carrier_now; // see (RULE_03)
                crs_oe_ff <= 1'b1;
            end
        end
    end

    // Pin levels read back for the GPIO role, two stages each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            col_meta_ff <= 1'b0;
            col_gpio_in_ff <= 1'b0;
            crs_meta_ff <= 1'b0;
            crs_gpio_in_ff <= 1'b0;
        end else if (ce) begin
            col_meta_ff <= col_in;
            col_gpio_in_ff <= col_meta_ff;
            crs_meta_ff <= crs_in;
            crs_gpio_in_ff <= crs_meta_ff;
        end
    end

    // Role decode for the transmit clock pin
    always_comb begin
        case (role_ff)
            ROLE_CLK_IN: begin
                nxt_role = want_clk_out ? ROLE_CLK_OUT : ROLE_CLK_IN; // see (RULE_09)
            end
            ROLE_CLK_OUT: begin
                nxt_role = want_clk_out ? ROLE_CLK_OUT : ROLE_CLK_IN; // see (RULE_06)
            end
            default: begin
                nxt_role = ROLE_CLK_IN;
            end
        endcase
    end

    // Role register, input role after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            role_ff <= ROLE_CLK_IN; // see (RULE_08)
        end else if (ce) begin
            role_ff <= nxt_role;
        end
    end

    // Transmit clock divider, runs only while the pin is an output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_div_ff <= '0;
            tx_clk_out_ff <= 1'b0;
            tx_clk_oe_ff <= 1'b0;
        end else if (ce) begin
            tx_clk_oe_ff <= (role_ff == ROLE_CLK_OUT); // see (RULE_07) see (RULE_06)
            if (role_ff != ROLE_CLK_OUT) begin
                // Input role: leave the pin to the MAC
                tx_div_ff <= '0;
                tx_clk_out_ff <= 1'b0;
            end else if (tx_div_ff + 1'b1 >= tx_half) begin
                tx_div_ff <= '0;
                tx_clk_out_ff <= !tx_clk_out_ff; // see (RULE_07)
            end else begin
                tx_div_ff <= tx_div_ff + 1'b1;
            end
        end
    end

    // Receive clock divider, free running
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_div_ff <= '0;
            rx_clk_out_ff <= 1'b0;
        end else if (ce) begin
            if (rx_div_ff + 1'b1 >= rx_half) begin
                rx_div_ff <= '0;
                rx_clk_out_ff <= !rx_clk_out_ff; // see (RULE_11)
            end else begin
                rx_div_ff <= rx_div_ff + 1'b1;
            end
        end
    end

    // The collision pin is level only; the MAC samples it asynchronously
    assign col_out = col_out_ff; // see (RULE_02)
    assign col_oe = col_oe_ff;
    assign crs_out = crs_out_ff;
    assign crs_oe = crs_oe_ff;
    assign col_gpio_in = col_gpio_in_ff;
    assign crs_gpio_in = crs_gpio_in_ff;
    assign tx_clk_out = tx_clk_out_ff;
    assign tx_clk_oe = tx_clk_oe_ff;
    assign rx_clk_out = rx_clk_out_ff;
    assign tx_word_valid = tx_word_valid_ff;
    assign tx_word = tx_word_ff;
    assign tx_overrun = tx_overrun_ff;
endmodule // mac_tx_if

// >>> sim/mac_tx_checker.sv
`timescale 1ns/10ps
module mac_tx_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic mii_select,
    input wire logic tx_clk_out_cfg,
    input wire logic tx_clk_oe,
    input wire mac_tx_pkg::link_speed_t speed,
    input wire logic link_up,
    input wire logic rx_clk_out,
    input wire logic half_duplex,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire mac_tx_pkg::pin_role_sel_t pin_role_select_register,
    input wire logic col_out,
    input wire logic col_oe,
    input wire logic crs_out,
    input wire logic tx_word_valid,
    input wire logic tx_word_ready,
    input wire mac_tx_pkg::tx_word_t tx_word,
    input wire logic tx_overrun
);
    import mac_tx_pkg::*;
    // Single domain; reset or a frozen clock enable aborts attempts
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset || !ce);
    // Role and rate conditions
    wire col_fn = !pin_role_select_register.col_gpio;
    wire crs_fn = !pin_role_select_register.crs_gpio;
    wire out_req = mii_select || tx_clk_out_cfg;
    wire fast_rx = link_up && (speed != SPEED_10);
    // Role request held long enough for role plus enable stage
    sequence out_held;
        out_req [*3];
    endsequence
    sequence in_held;
        !out_req [*3];
    endsequence
    // Word offered, not yet taken
    sequence word_waiting;
        tx_word_valid && !tx_word_ready;
    endsequence
    chk_col_half: assert property (col_fn && half_duplex && rx_active && tx_active |=> col_out)
        else $error("collision not raised");
    chk_col_full: assert property (col_fn && !half_duplex |=> !col_out)
        else $error("collision in full duplex");
    chk_crs_carrier: assert property (crs_fn && half_duplex |=> crs_out == $past(rx_active || tx_active))
        else $error("carrier sense wrong");
    chk_col_drive: assert property (col_fn |=> col_oe)
        else $error("collision pin not driven");
    chk_gpio_copy: assert property (!col_fn |=> col_out == $past(pin_role_select_register.col_gpio_out)
        && col_oe == $past(pin_role_select_register.col_gpio_oe))
        else $error("gpio role not copied");
    chk_role_out: assert property (out_held |-> tx_clk_oe)
        else $error("clock pin not output");
    chk_role_default: assert property (in_held |-> !tx_clk_oe)
        else $error("clock pin not input");
    chk_rx_fast: assert property (fast_rx [*3] |-> $changed(rx_clk_out))
        else $error("receive clock stalled");
    chk_word_hold: assert property (word_waiting |=> tx_word_valid && $stable(tx_word))
        else $error("word not held");
    chk_overrun_sticky: assert property (tx_overrun |=> tx_overrun)
        else $error("overrun flag lost");
endmodule // mac_tx_checker

bind mac_tx_if mac_tx_checker chk (.clk_sys, .reset, .ce, .mii_select, .tx_clk_out_cfg, .tx_clk_oe, .speed, .link_up,
    .rx_clk_out, .half_duplex, .rx_active, .tx_active, .pin_role_select_register, .col_out, .col_oe, .crs_out,
    .tx_word_valid, .tx_word_ready, .tx_word, .tx_overrun);

// >>> sim/mac_link_model.sv
`timescale 1ns/10ps
module mac_link_model (
    output logic link_clk,
    output logic [mac_tx_pkg::NIBBLE_W-1:0] tx_data_pin,
    output logic tx_ctl_pin
);
    import mac_tx_pkg::*;
    // Continuous MAC clock, phase offset from the system clock
    initial begin
        link_clk = 1'b0;
        tx_data_pin = 4'h0;
        tx_ctl_pin = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end
    // One link cycle; lines change away from both edges
    task automatic cycle(input logic [3:0] lo, input logic [3:0] hi, input logic ctl_r, input logic ctl_f);
        @(negedge link_clk);
        #4;
        tx_data_pin = lo;
        tx_ctl_pin = ctl_r;
        @(posedge link_clk);
        #4;
        tx_data_pin = hi;
        tx_ctl_pin = ctl_f;
    endtask
endmodule // mac_link_model

// >>> sim/mac_tx_if_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h seen %h", n, e, g); end end
module mac_tx_if_tb;
    import mac_tx_pkg::*;
    // Inputs, all valued at time zero
    logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1;
    logic mii_select = 1'b0, tx_clk_out_cfg = 1'b0, link_up = 1'b0;
    logic half_duplex = 1'b0, rx_active = 1'b0, tx_active = 1'b0;
    logic ext_col = 1'b0, ext_crs = 1'b0, tx_word_ready = 1'b0, rnd_rdy = 1'b0;
    link_speed_t speed = SPEED_10;
    pin_role_sel_t pin_role_select_register = '0;
    logic link_clk, tx_ctl_pin, tx_clk_out, tx_clk_oe, rx_clk_out, col_out, col_oe, crs_out, crs_oe;
    logic col_gpio_in, crs_gpio_in, tx_word_valid, tx_overrun, ec, es;
    logic [NIBBLE_W-1:0] tx_data_pin;
    tx_word_t tx_word;
    // Reference queue of words in flight
    logic [TX_WORD_W-1:0] exp_q[$], exp_w;
    int seed = 12, bad_count = 0, samples_checked = 0, pops = 0, cycles = 0, i, k;
    // Pin levels; the random ext_col and ext_crs levels stand in when nobody drives
    wire col_in = col_oe ? col_out : ext_col;
    wire crs_in = crs_oe ? crs_out : ext_crs;
    mac_tx_if dut (.*);
    mac_link_model mac (.link_clk, .tx_data_pin, .tx_ctl_pin);
    always #50 clk_sys = ~clk_sys;
    // Random sink stalls, driven at falling edge
    always @(negedge clk_sys) tx_word_ready <= rnd_rdy && ($random(seed) % 4 != 0);
    // Every accepted word against the reference
    always @(posedge clk_sys) begin
        if (!reset && tx_word_valid === 1'b1 && tx_word_ready === 1'b1) begin
            exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            pops++;
            `CHK("tx_word", exp_w, tx_word)
        end
    end
    // Hang guard, far above the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic sys(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_reset;
        reset = 1'b1;
        sys(6);
        reset = 1'b0;
        sys(4);
    endtask
    // Changes of a clock output over 40 cycles
    task automatic toggles(input logic tx, output int n);
        logic p, v;
        n = 0;
        p = tx ? tx_clk_out : rx_clk_out;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            v = tx ? tx_clk_out : rx_clk_out;
            n += (v !== p);
            p = v;
        end
        @(negedge clk_sys);
    endtask
    // Frame of n words; MII keeps enable on both halves
    task automatic frame(input int n);
        logic [3:0] lo, hi;
        logic cf;
        for (int j = 0; j < n; j++) begin
            lo = 4'($random(seed));
            hi = mii_select ? lo : 4'($random(seed));
            cf = mii_select ? 1'b1 : 1'($random(seed));
            exp_q.push_back(mii_select ? {2'b00, 4'h0, lo} : {1'b1, ~cf, hi, lo});
            mac.cycle(lo, hi, 1'b1, cf);
        end
        repeat (4) mac.cycle(4'h0, 4'h0, 1'b0, 1'b0);
    endtask
    task automatic drain;
        for (int j = 0; j < 300 && exp_q.size() > 0; j++) sys(1);
        sys(10);
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        do_reset();
        `CHK("oe_reset", 1'b0, tx_clk_oe)
        // Duplex and activity table, both pin roles
        for (i = 0; i < 16; i++) begin
            {pin_role_select_register, ext_col, ext_crs} = 8'($random(seed));
            {half_duplex, rx_active, tx_active} = 3'(i);
            pin_role_select_register.col_gpio = i[3];
            pin_role_select_register.crs_gpio = i[3];
            ec = i[3] ? pin_role_select_register.col_gpio_out : &i[2:0];
            es = i[3] ? pin_role_select_register.crs_gpio_out : i[2] & (i[1] | i[0]);
            sys(6);
            `CHK("col", ec, col_out)
            `CHK("crs", es, crs_out)
            `CHK("col_oe", !i[3] | pin_role_select_register.col_gpio_oe, col_oe)
            `CHK("col_pin", (!i[3] | pin_role_select_register.col_gpio_oe) ? ec : ext_col, col_gpio_in)
            `CHK("crs_oe", !i[3] | pin_role_select_register.crs_gpio_oe, crs_oe)
            `CHK("crs_pin", (!i[3] | pin_role_select_register.crs_gpio_oe) ? es : ext_crs, crs_gpio_in)
        end
        mii_select = 1'b1;
        sys(4);
        `CHK("oe_mii", 1'b1, tx_clk_oe)
        toggles(1'b1, k);
        `CHK("tx_clk_10", 40 / HALF_SLOW, k)
        speed = SPEED_100;
        sys(4);
        toggles(1'b1, k);
        `CHK("tx_clk_100", 40 / HALF_FAST, k)
        // Receive clock per speed, last pass without link
        for (i = 0; i < 4; i++) begin
            link_up = (i < 3);
            speed = link_speed_t'(i == 3 ? 2 : i);
            sys(4);
            toggles(1'b0, k);
            `CHK("rx_clk", 40 / (i == 1 ? HALF_FAST : i == 2 ? HALF_GIG : HALF_SLOW), k)
        end
        // Clock enable low must freeze the free running divider
        ce = 1'b0;
        toggles(1'b0, k);
        `CHK("ce_freeze", 0, k)
        ce = 1'b1;
        sys(2);
        // MII frames first, then dual-edge frames
        rnd_rdy = 1'b1;
        for (i = 0; i < 6; i++) begin
            mii_select = (i < 2);
            sys(4);
            frame(3 + i);
            drain();
        end
        `CHK("words_left", 0, exp_q.size())
        tx_clk_out_cfg = 1'b1;
        sys(4);
        `CHK("oe_cfg", 1'b1, tx_clk_oe)
        tx_clk_out_cfg = 1'b0;
        sys(4);
        `CHK("oe_input", 1'b0, tx_clk_oe)
        // Flood with the sink stalled until words are refused
        rnd_rdy = 1'b0;
        pops = 0;
        frame(24);
        sys(10);
        `CHK("overrun", 1'b1, tx_overrun)
        rnd_rdy = 1'b1;
        sys(100);
        `CHK("kept_words", 1'b1, pops >= FIFO_DEPTH)
        exp_q.delete();
        do_reset();
        `CHK("overrun_clear", 1'b0, tx_overrun)
        summarize();
    end
endmodule // mac_tx_if_tb
